/* hdl/ppe_encoder.sv */
`timescale 1ns/1ps
// Functional notes
// - Physical address: bits 55:0 in bytes 0-6, byte 7 bits 6:0 zero.
// - Physical address byte 7 bit 7 is one for non-secure space.
// - Virtual address: byte 7 is tag when top-byte-ignore set, else zero.
// - Instruction address byte 7 bit 7 gives security state, one non-secure.
// - Instruction address byte 7 bits 6:5 carry privilege level.
// - Instruction address byte 7 bits 4:0 are zero.
// - Alignment command: byte 0 is 001,0,size code; byte 1 zero.
// - Size code 1..15 selects 4 bytes to 64 Kbyte; others reserved.
// - Next header starts on a multiple of the size; filler below size.
// - Context header 01,10,01,selector then 32-bit payload.
// - Selector 0 level-1 id if gathered; 1 level-2 id non-secure only.
// - Context payload least significant byte first.
// - Short counter header 10,01,1,index; only when index bits 4:3 zero.
// - Extended counter prefix 001,000,index 4:3, then short-style header.
// - Index 0 total latency, index 1 issue latency, for every operation.
// - Index 2 translation latency for memory ops; others impl or reserved.
// - Counters are 12-bit saturating; payload byte 1 bits 7:4 zero.
// - Bytes go out in ascending order, values least significant first.
// - Every address packet carries a full 64-bit payload.
module ppe_encoder
  import ppe_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire ppe_req_t req_kind,
  input wire logic [4:0] req_index,
  input wire logic [63:0] req_addr,
  input wire logic security_attr_bit,
  input wire logic top_byte_ignore_ctl,
  input wire logic [1:0] privilege_level_field,
  input wire logic [3:0] req_align_code,
  input wire logic [1:0] req_ctx_sel,
  input wire logic [31:0] process_id_level1,
  input wire logic [31:0] process_id_level2,
  input wire logic gather_process_id_level1,
  input wire logic gather_process_id_level2,
  input wire logic [CNT_W-1:0] req_count,
  input wire logic op_dispatch,
  input wire logic op_issue,
  input wire logic op_complete,
  input wire logic xlat_start,
  input wire logic xlat_done,
  output logic [CNT_W-1:0] total_latency,
  output logic [CNT_W-1:0] issue_latency,
  output logic [CNT_W-1:0] xlat_latency,
  output logic req_error,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [7:0] byte_data,
  output logic [PPE_PTR_W-1:0] write_offset
);
  // ----------------------------------------
  // Latency counters
  // ----------------------------------------
  // Total and issue latency
  ppe_lat_counter #(.CNT_W(CNT_W)) u_total (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(op_dispatch),
    .stop(op_complete),
    .count(total_latency),
    .running()
  );

  ppe_lat_counter #(.CNT_W(CNT_W)) u_issue (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(op_dispatch),
    .stop(op_issue),
    .count(issue_latency),
    .running()
  );

  ppe_lat_counter #(.CNT_W(CNT_W)) u_xlat (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(xlat_start),
    .stop(xlat_done),
    .count(xlat_latency),
    .running()
  );

  // ----------------------------------------
  // Packet assembly
  // ----------------------------------------
  typedef enum logic [1:0] {
    PPE_IDLE,
    PPE_EMIT,
    PPE_FILL
  } ppe_state_t;

  ppe_state_t state;
  logic [7:0] pkt [10];
  logic [3:0] pkt_len;
  logic [3:0] pkt_pos;
  logic [PPE_PTR_W-1:0] fill_mask;
  logic [7:0] next_pkt [10];
  logic [3:0] next_len;
  logic next_bad;
  logic [7:0] addr_top;
  logic [11:0] cnt12;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic emit_take;

  assign cnt12 = (req_count > CNT_W'(PPE_CNT_SAT)) ? PPE_CNT_SAT : req_count[11:0];

  always_comb begin
    next_len = 4'h0;
    next_bad = 1'b0;
    addr_top = 8'h00;
    for (int i = 0; i < 10; i++) begin
      next_pkt[i] = 8'h00;
    end
    unique case (req_kind)
      PPE_REQ_PADDR, PPE_REQ_VADDR, PPE_REQ_IADDR: begin
        unique case (req_kind)
          PPE_REQ_PADDR: addr_top = {security_attr_bit, 7'h00};
          PPE_REQ_VADDR: addr_top = top_byte_ignore_ctl ? req_addr[63:56] : 8'h00;
          default: addr_top = {security_attr_bit, privilege_level_field, 5'h00};
        endcase
        // Address packets carry no header byte; payload only here
        // Full eight-byte payload
        for (int i = 0; i < 7; i++) begin
          next_pkt[i] = req_addr[8*i +: 8];
        end
        next_pkt[7] = addr_top;
        next_len = 4'd8;
      end
      PPE_REQ_ALIGN: begin
        next_bad = (req_align_code < PPE_ALIGN_MIN);
        next_pkt[0] = PPE_ALIGN_BASE | {4'h0, req_align_code};
        next_pkt[1] = 8'h00;
        next_len = 4'd2;
      end
      PPE_REQ_CTX: begin
        next_bad = (req_ctx_sel == PPE_CTX_SEL_L1) ? !gather_process_id_level1 :
                   (req_ctx_sel == PPE_CTX_SEL_L2) ?
                   !(gather_process_id_level2 && security_attr_bit) : 1'b1;
        next_pkt[0] = PPE_CTX_HDR_BASE | {6'h00, req_ctx_sel};
        for (int i = 0; i < 4; i++) begin
          next_pkt[i+1] = (req_ctx_sel == PPE_CTX_SEL_L1) ?
                          process_id_level1[8*i +: 8] : process_id_level2[8*i +: 8];
        end
        next_len = 4'd5;
      end
      default: begin
        if (req_index[4:3] == 2'h0) begin
          next_pkt[0] = PPE_CNT_HDR_BASE | {5'h00, req_index[2:0]};
          next_pkt[1] = cnt12[7:0];
          next_pkt[2] = {4'h0, cnt12[11:8]};
          next_len = 4'd3;
        end else begin
          next_pkt[0] = PPE_PREFIX_BASE | {6'h00, req_index[4:3]};
          next_pkt[1] = PPE_CNT_HDR_BASE | {5'h00, req_index[2:0]};
          next_pkt[2] = cnt12[7:0];
          next_pkt[3] = {4'h0, cnt12[11:8]};
          next_len = 4'd4;
        end
        next_bad = (req_index > PPE_CNT_XLAT) && (req_index[4:1] != 4'h3) &&
                   !req_index[4];
      end
    endcase
  end

  assign req_ready = (state == PPE_IDLE);
  assign emit_take = fifo_in_valid && fifo_in_ready;

  always_comb begin
    fifo_in_valid = (state != PPE_IDLE);
    fifo_in_data = (state == PPE_EMIT) ? pkt[pkt_pos] : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= PPE_IDLE;
      pkt_len <= 4'h0;
      pkt_pos <= 4'h0;
      fill_mask <= '0;
      req_error <= 1'b0;
    end else begin
      req_error <= 1'b0;
      unique case (state)
        PPE_IDLE: begin
          if (req_valid) begin
            if (next_bad) begin
              req_error <= 1'b1;
            end else begin
              pkt_len <= next_len;
              pkt_pos <= 4'h0;
              // Alignment bytes are 4 << (code-1), i.e. 1 << (code+1)
              // Five-bit shift amount: code 15 must reach bit 16, not wrap to 0
              fill_mask <= (req_kind == PPE_REQ_ALIGN) ?
                PPE_PTR_W'((32'h1 << (5'(req_align_code) + 5'(PPE_ALIGN_LOG_OFS))) - 32'h1) : '0;
              state <= PPE_EMIT;
            end
          end
        end
        PPE_EMIT: begin
          if (emit_take && (pkt_pos == pkt_len - 4'h1)) begin
            state <= (((write_offset + 1'b1) & fill_mask) != '0) ? PPE_FILL : PPE_IDLE;
          end else if (emit_take) begin
            pkt_pos <= pkt_pos + 4'h1;
          end
        end
        PPE_FILL: begin
          if (emit_take && (((write_offset + 1'b1) & fill_mask) == '0)) begin
            state <= PPE_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 10; i++) begin
        pkt[i] <= 8'h00;
      end
    end else if (state == PPE_IDLE && req_valid && !next_bad) begin
      for (int i = 0; i < 10; i++) begin
        pkt[i] <= next_pkt[i];
      end
    end
  end

  // Offset counts bytes handed to the buffer; wraps at 64 Kbyte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      write_offset <= '0;
    end else if (emit_take) begin
      write_offset <= write_offset + 1'b1;
    end
  end

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  // Back-pressure from the buffer writer stalls emission
  ppe_fifo #(.WIDTH(8), .DEPTH(PPE_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(byte_data)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  align_fill_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == PPE_FILL) && emit_take |->
      (fifo_in_data == 8'h00) && (fill_mask != '0) && (pkt_len == 4'd2))
    else $error("filler byte not zero");

  fill_end_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(state) != PPE_IDLE && state == PPE_IDLE && fill_mask != '0 |->
      ((write_offset & fill_mask) == '0))
    else $error("next header not aligned");

  busy_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == PPE_EMIT) && !emit_take |=> $stable(pkt_pos))
    else $error("position moved without a byte");

  ctx_hdr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_kind == PPE_REQ_CTX && !next_bad |->
      next_pkt[0][7:2] == 6'h19 && next_len == 4'd5)
    else $error("bad context header");

  cnt_pay_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_CNT && req_index[4:3] == 2'h0 |->
      next_pkt[2][7:4] == 4'h0)
    else $error("counter top nibble set");

  addr_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_kind == PPE_REQ_PADDR |=>
      pkt_len == 4'd8 && pkt[7][6:0] == 7'h00)
    else $error("address payload short");

  iaddr_low_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_IADDR |-> next_pkt[7][4:0] == 5'h00)
    else $error("instruction byte 7 low bits set");

  l2_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_kind == PPE_REQ_CTX &&
      req_ctx_sel == PPE_CTX_SEL_L2 && !security_attr_bit |=> req_error)
    else $error("level-2 id emitted in secure state");

  align_mask_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && req_kind == PPE_REQ_ALIGN && !next_bad |=>
      fill_mask[1:0] == 2'h3 && ((fill_mask + 1'b1) & fill_mask) == '0)
    else $error("alignment mask not a power of two");

  align_cmd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_ALIGN |->
      next_pkt[0][7:4] == 4'h2 && next_pkt[0][3:0] == req_align_code && next_pkt[1] == 8'h00)
    else $error("bad alignment command");

  cnt_short_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_CNT && req_index[4:3] == 2'h0 |->
      next_pkt[0][7:3] == 5'h13 && next_pkt[0][2:0] == req_index[2:0] && next_len == 4'd3)
    else $error("bad short counter header");

  cnt_ext_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_CNT && req_index[4:3] != 2'h0 |->
      next_pkt[0] == {6'h08, req_index[4:3]} && next_pkt[1][7:3] == 5'h13 && next_len == 4'd4)
    else $error("bad extended counter header");

  ctx_order_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_kind == PPE_REQ_CTX && req_ctx_sel == PPE_CTX_SEL_L1 |->
      next_pkt[1] == process_id_level1[7:0] && next_pkt[4] == process_id_level1[31:24])
    else $error("context bytes out of order");

  refuse_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_valid && req_ready && next_bad |=> state == PPE_IDLE && req_error)
    else $error("refused request emitted bytes");
endmodule

/* hdl/ppe_fifo.sv */
`timescale 1ns/1ps
module ppe_fifo
  import ppe_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = PPE_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Full FIFO never accepts a byte, nor moves its write side
  fifo_no_ovf_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fill == (AW+1)'(DEPTH)) && !pop |-> !in_ready ##1
      (fill == (AW+1)'(DEPTH)) && $stable(wr_ptr))
    else $error("fifo accepts while full");
endmodule

/* hdl/ppe_lat_counter.sv */
`timescale 1ns/1ps
module ppe_lat_counter
  import ppe_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic stop,
  output logic [CNT_W-1:0] count,
  output logic running
);
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count <= '0;
      running <= 1'b0;
    end else if (start) begin
      count <= CNT_W'(1);
      running <= !stop;
    end else if (running) begin
      if (count != '1) begin
        count <= count + 1'b1;
      end
      if (stop) begin
        running <= 1'b0;
      end
    end
  end

  sat_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (count == '1) && !start |=> (count == '1))
    else $error("saturated count moved");
endmodule

/* hdl/ppe_pkg.sv */
package ppe_pkg;
  // ----------------------------------------
  // Packet field constants
  // ----------------------------------------
  localparam logic [7:0] PPE_PREFIX_BASE = 8'h20;
  localparam logic [7:0] PPE_ALIGN_BASE = 8'h20;
  localparam logic [7:0] PPE_CTX_HDR_BASE = 8'h64;
  localparam logic [7:0] PPE_CNT_HDR_BASE = 8'h98;
  localparam logic [1:0] PPE_CTX_SEL_L1 = 2'h0;
  localparam logic [1:0] PPE_CTX_SEL_L2 = 2'h1;
  localparam logic [4:0] PPE_CNT_TOTAL = 5'h00;
  localparam logic [4:0] PPE_CNT_ISSUE = 5'h01;
  localparam logic [4:0] PPE_CNT_XLAT = 5'h02;
  localparam logic [11:0] PPE_CNT_SAT = 12'hfff;
  localparam logic [11:0] PPE_CNT_RESET = 12'h000;
  localparam logic [3:0] PPE_ALIGN_MIN = 4'h1;
  localparam logic [3:0] PPE_ALIGN_MAX = 4'hf;
  localparam logic [1:0] PPE_ALIGN_LOG_OFS = 2'h1;
  localparam int PPE_FIFO_DEPTH = 8;
  localparam int PPE_PTR_W = 16;

  // ----------------------------------------
  // Request kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    PPE_REQ_PADDR,
    PPE_REQ_VADDR,
    PPE_REQ_IADDR,
    PPE_REQ_ALIGN,
    PPE_REQ_CTX,
    PPE_REQ_CNT
  } ppe_req_t;
endpackage

/* testbench/ppe_sink.sv */
`timescale 1ns/1ps
module ppe_sink (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data
);
  logic [7:0] mem [0:1023];
  int cnt;
  logic phase;
  // ----------------------------------------
  // Buffer memory
  // ----------------------------------------
  // filler kept raw
  // Bytes land blindly; mode 1 stalls every other cycle, mode 2 stalls fully
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cnt <= 0;
      phase <= 1'b0;
      byte_ready <= 1'b0;
    end else begin
      phase <= ~phase;
      byte_ready <= (mode == 2'h0) || (mode == 2'h1 && phase);
      if (byte_valid && byte_ready) begin
        mem[cnt] <= byte_data;
        cnt <= cnt + 1;
      end
    end
  end
endmodule

/* testbench/profile_packet_encoder_test.sv */
`timescale 1ns/1ps
module profile_packet_encoder_test;
  import ppe_pkg::*;
  logic core_clk, reset_n, req_valid, req_ready, req_error, byte_valid, byte_ready;
  ppe_req_t req_kind;
  logic [4:0] req_index;
  logic [63:0] req_addr;
  logic security_attr_bit, top_byte_ignore_ctl;
  logic [1:0] privilege_level_field, req_ctx_sel, sink_mode;
  logic [3:0] req_align_code;
  logic [31:0] process_id_level1, process_id_level2;
  logic gather_process_id_level1, gather_process_id_level2;
  logic [11:0] req_count, total_latency, issue_latency, xlat_latency;
  logic op_dispatch, op_issue, op_complete, xlat_start, xlat_done;
  logic [7:0] byte_data;
  logic [15:0] write_offset;
  int err_count, n_compared, base;
  logic [7:0] exp [$];

  ppe_encoder i_dut (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_index(req_index), .req_addr(req_addr),
    .security_attr_bit(security_attr_bit), .top_byte_ignore_ctl(top_byte_ignore_ctl),
    .privilege_level_field(privilege_level_field), .req_align_code(req_align_code),
    .req_ctx_sel(req_ctx_sel), .process_id_level1(process_id_level1),
    .process_id_level2(process_id_level2), .gather_process_id_level1(gather_process_id_level1),
    .gather_process_id_level2(gather_process_id_level2), .req_count(req_count),
    .op_dispatch(op_dispatch), .op_issue(op_issue), .op_complete(op_complete),
    .xlat_start(xlat_start), .xlat_done(xlat_done), .total_latency(total_latency),
    .issue_latency(issue_latency), .xlat_latency(xlat_latency), .req_error(req_error),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
    .write_offset(write_offset));
  ppe_sink i_sink (.core_clk(core_clk), .reset_n(reset_n), .mode(sink_mode),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("ERROR %0t: wait ran out", $time);
    summarize();
  endtask

  // Request held until taken; bytes then compared against the buffer
  task automatic issue(input bit refuse, input int hold);
    int i;
    bit err_seen;
    err_seen = 1'b0;
    i = 0;
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    do begin
      @(negedge core_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 100);
    if (i >= 100) timeout();
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    repeat (3) begin
      @(negedge core_clk);
      if (req_error === 1'b1) err_seen = 1'b1;
    end
    chk(err_seen, refuse, "refusal flag");
    if (hold > 0) begin
      repeat (hold) @(negedge core_clk);
      chk(write_offset, 16'h0008, "fifo fill");
      chk(req_ready, 1'b0, "busy while full");
      chk(byte_valid, 1'b1, "fifo head");
      sink_mode = 2'h0;
    end
    i = 0;
    while (i_sink.cnt < base + exp.size() && i < 400) begin
      @(negedge core_clk);
      i++;
    end
    if (i >= 400) timeout();
    foreach (exp[b]) chk(i_sink.mem[base + b], exp[b], "buffer byte");
    base += exp.size();
    exp.delete();
    chk(16'(i_sink.cnt), 16'(base), "byte count");
    chk(write_offset, 16'(base), "write offset");
    chk(byte_valid, 1'b0, "fifo drained");
  endtask

  task automatic add_addr();
    for (int b = 0; b < 7; b++) exp.push_back(req_addr[8*b +: 8]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fifo();
    sink_mode = 2'h2;
    req_kind = PPE_REQ_ALIGN;
    req_align_code = 4'h3;
    exp = '{8'h23, 8'h00};
    while (exp.size() < 16) exp.push_back(8'h00);
    issue(1'b0, 20);
  endtask

  task automatic t_addr();
    sink_mode = 2'h1;
    req_addr = 64'ha5f0e1d2c3b4a596;
    for (int k = 0; k < 4; k++) begin
      security_attr_bit = k[0];
      top_byte_ignore_ctl = k[1];
      privilege_level_field = k[1:0];
      req_kind = PPE_REQ_PADDR;
      add_addr();
      exp.push_back({security_attr_bit, 7'h00});
      issue(1'b0, 0);
      req_kind = PPE_REQ_VADDR;
      add_addr();
      exp.push_back(top_byte_ignore_ctl ? req_addr[63:56] : 8'h00);
      issue(1'b0, 0);
      req_kind = PPE_REQ_IADDR;
      add_addr();
      exp.push_back({security_attr_bit, privilege_level_field, 5'h00});
      issue(1'b0, 0);
    end
    sink_mode = 2'h0;
  endtask

  task automatic t_align();
    req_kind = PPE_REQ_ALIGN;
    req_align_code = 4'h0;
    issue(1'b1, 0);
    for (int c = 1; c < 6; c++) begin
      req_align_code = c[3:0];
      exp.push_back({4'h2, req_align_code});
      exp.push_back(8'h00);
      while ((base + exp.size()) % (2 << c) != 0) exp.push_back(8'h00);
      issue(1'b0, 0);
    end
  endtask

  task automatic t_ctx();
    req_kind = PPE_REQ_CTX;
    security_attr_bit = 1'b1;
    for (int s = 0; s < 4; s++) begin
      req_ctx_sel = s[1:0];
      if (s < 2) begin
        exp.push_back({6'h19, req_ctx_sel});
        for (int b = 0; b < 4; b++) begin
          exp.push_back(s[0] ? process_id_level2[8*b +: 8] : process_id_level1[8*b +: 8]);
        end
      end
      issue(s > 1, 0);
    end
    req_ctx_sel = 2'h1;
    security_attr_bit = 1'b0;
    issue(1'b1, 0);
    security_attr_bit = 1'b1;
    gather_process_id_level2 = 1'b0;
    issue(1'b1, 0);
    req_ctx_sel = 2'h0;
    gather_process_id_level1 = 1'b0;
    issue(1'b1, 0);
  endtask

  task automatic t_cnt();
    int idx [9] = '{0, 1, 2, 6, 7, 16, 31, 3, 9};
    req_kind = PPE_REQ_CNT;
    foreach (idx[k]) begin
      req_index = idx[k][4:0];
      req_count = k[0] ? 12'hfff : 12'h5a3;
      if (k < 7) begin
        if (req_index[4:3] != 2'h0) exp.push_back({6'h08, req_index[4:3]});
        exp.push_back({5'h13, req_index[2:0]});
        exp.push_back(req_count[7:0]);
        exp.push_back({4'h0, req_count[11:8]});
      end
      issue(k >= 7, 0);
    end
  endtask

  // Pulses one per cycle; count is inclusive of start and stop cycles
  task automatic t_lat();
    for (int c = 0; c < 10; c++) begin
      @(posedge core_clk);
      #1;
      op_dispatch = (c == 0);
      op_issue = (c == 3);
      op_complete = (c == 8);
      xlat_start = (c == 1);
      xlat_done = (c == 6);
    end
    repeat (2) @(negedge core_clk);
    chk(issue_latency, 12'h004, "issue latency");
    chk(total_latency, 12'h009, "total latency");
    chk(xlat_latency, 12'h006, "translation latency");
    @(posedge core_clk);
    #1 op_dispatch = 1'b1;
    @(posedge core_clk);
    #1 op_dispatch = 1'b0;
    repeat (4200) @(posedge core_clk);
    #1 op_complete = 1'b1;
    @(posedge core_clk);
    #1 op_complete = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(total_latency, 12'hfff, "saturated count");
  endtask

  // Largest boundary; only the first stretch of filler is inspected
  task automatic t_align_max();
    req_kind = PPE_REQ_ALIGN;
    req_align_code = 4'hf;
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    repeat (40) @(negedge core_clk);
    chk(req_ready, 1'b0, "still padding");
    chk(i_sink.mem[base], 8'h2f, "largest size code");
    chk(i_sink.mem[base + 1], 8'h00, "command byte 1");
    chk(i_sink.mem[base + 20], 8'h00, "wide filler");
  endtask

  initial begin
    err_count = 0;
    n_compared = 0;
    base = 0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_kind = PPE_REQ_PADDR;
    req_index = 5'h00;
    req_addr = 64'h0;
    security_attr_bit = 1'b1;
    top_byte_ignore_ctl = 1'b0;
    privilege_level_field = 2'h0;
    req_align_code = 4'h1;
    req_ctx_sel = 2'h0;
    process_id_level1 = 32'h1a2b3c4d;
    process_id_level2 = 32'h5e6f7081;
    gather_process_id_level1 = 1'b1;
    gather_process_id_level2 = 1'b1;
    req_count = 12'h000;
    {op_dispatch, op_issue, op_complete, xlat_start, xlat_done} = 5'h00;
    sink_mode = 2'h0;
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1'b1;
    @(negedge core_clk);
    chk(req_ready, 1'b1, "ready after reset");
    chk(byte_valid, 1'b0, "empty after reset");
    chk(write_offset, 16'h0000, "offset after reset");
    chk(total_latency, 12'h000, "count after reset");
    t_fifo();
    t_addr();
    t_align();
    t_ctx();
    t_cnt();
    t_lat();
    t_align_max();
    summarize();
  end
endmodule
